// >>> tcm_pkg.sv
// Purpose: shared constants for the 16-bit timer compare output stage
// Assumes: 100 MHz system clock, prescaler ticks supplied from outside
// Notes:   register offsets are word indices on the plain register port
package tcm_pkg;
  // ==========================================================
  // register offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_COUNT  = 4'h1;
  localparam logic [3:0] REG_CMPA   = 4'h2;
  localparam logic [3:0] REG_CMPB   = 4'h3;
  localparam logic [3:0] REG_CMPC   = 4'h4;
  localparam logic [3:0] REG_CAPT   = 4'h5;
  localparam logic [3:0] REG_FLAGS  = 4'h6;
  localparam logic [3:0] REG_FORCE  = 4'h7;
  localparam logic [3:0] REG_PORT   = 4'h8;
  // ==========================================================
  // control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_ACTA_LSB = 4;
  localparam int CTRL_ACTB_LSB = 6;
  localparam int CTRL_ACTC_LSB = 8;
  // flag bit positions
  localparam int FLG_OVF  = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int FLG_CMPC = 3;
  localparam int FLG_CAPT = 4;
  // ==========================================================
  // reset values and modes
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [3:0]  MODE_NORM  = 4'h0;
  localparam logic [3:0]  MODE_CTCA  = 4'h4;
  localparam logic [3:0]  MODE_CTCI  = 4'hc;
  localparam logic [1:0]  ACT_NONE   = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE = 2'h1;
  localparam logic [1:0]  ACT_CLEAR  = 2'h2;
  localparam logic [1:0]  ACT_SET    = 2'h3;
  localparam int          NUM_CH     = 3;
endpackage

// >>> tcm_out_latch.sv
// Purpose: one compare output latch with pin override
// Assumes: tick, match and force come from the same clock domain
// Notes:   pwm action handling is outside this stage
`timescale 1ns/10ps
module tcm_out_latch
  import tcm_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  input  wire logic       tick,
  input  wire logic       match,
  input  wire logic       force_compare_strobe,
  input  wire logic [1:0] compare_output_action_field,
  input  wire logic       portValue,
  input  wire logic       output_pin_direction_bit,
  output logic            compare_output_latch,
  output logic            pinOut,
  output logic            pinOe
);
  // ==========================================================
  // next latch value from the action field
  function automatic logic applyAct(input logic [1:0] act, input logic cur);
    case (act)
      ACT_TOGGLE: applyAct = ~cur;
      ACT_CLEAR:  applyAct = 1'b0;
      ACT_SET:    applyAct = 1'b1;
      default:    applyAct = cur;
    endcase
  endfunction

  wire logic doUpdate = (tick && match) ||
                        force_compare_strobe;
  wire logic next_latch = doUpdate ?
    applyAct(compare_output_action_field, compare_output_latch) :
    compare_output_latch;
  wire logic overrideOn = |compare_output_action_field;
  wire logic next_pin = overrideOn ? compare_output_latch : portValue;

  // ==========================================================
  // latch and pin registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      compare_output_latch <= 1'b0;
      pinOut               <= 1'b0;
      pinOe                <= 1'b0;
    end else if (clkEn) begin
      compare_output_latch <= next_latch;
      pinOut               <= next_pin & output_pin_direction_bit;
      pinOe                <= output_pin_direction_bit;
    end
  end

  a_latch_reset: assert property (@(posedge clk_sys) !rst_n |=>
    !compare_output_latch) else $error("latch not cleared");
  a_hold_none: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && compare_output_action_field == ACT_NONE |=>
    $stable(compare_output_latch)) else $error("latch moved");
endmodule

// >>> tcm_counter.sv
// Purpose: 16-bit counter for normal and clear-on-match modes
// Assumes: one tick pulse per prescaled timer clock
// Notes:   pwm counting modes hold the count
`timescale 1ns/10ps
module tcm_counter
  import tcm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic        tick,
  input  wire logic [3:0]  waveform_mode_select,
  input  wire logic        cntWrite,
  input  wire logic [15:0] cntWData,
  input  wire logic [15:0] topValue,
  output logic [15:0]      counter_value,
  output logic             wrapEvt
);
  // ==========================================================
  // counting sequence depends on mode and top value
  wire logic isCtc = (waveform_mode_select == MODE_CTCA) ||
                     (waveform_mode_select == MODE_CTCI);
  wire logic isNorm = waveform_mode_select == MODE_NORM;
  wire logic atTop = isCtc && (counter_value == topValue);
  wire logic atMax = counter_value == CNT_MAX;
  wire logic [15:0] next_count = atTop ? RST_WORD :
    counter_value + 16'h0001;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      counter_value <= RST_WORD;
      wrapEvt       <= 1'b0;
    end else if (clkEn) begin
      wrapEvt <= 1'b0;
      if (cntWrite) begin
        counter_value <= cntWData;
      end else if (tick && (isNorm || isCtc)) begin
        counter_value <= next_count;
        wrapEvt       <= atMax && !atTop;
      end
    end
  end

  a_ctc_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && tick && !cntWrite && atTop |=> counter_value == RST_WORD)
    else $error("no clear at top");
  a_norm_inc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && tick && !cntWrite && isNorm |=>
    counter_value == $past(counter_value) + 16'h0001)
    else $error("normal not incrementing");
endmodule

// >>> tcm_timer16.sv
// Purpose: compare output stage and non-pwm modes of a 16-bit timer
// Assumes: timerTick from a prescaler on clk_sys, pins synchronised here
// Notes:   registers on a plain port, read data one cycle after strobe
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/10ps
module tcm_timer16
  import tcm_pkg::*;
#(
  parameter int CH = NUM_CH
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic        timerTick,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic        ovfIntAck,
  input  wire logic        capIntAck,
  input  wire logic        captureEvt,
  input  wire logic [2:0]  portValuePin,
  input  wire logic [2:0]  pinDirPin,
  output logic [15:0]      regRData,
  output logic [2:0]       pinOut,
  output logic [2:0]       pinOe,
  output logic [2:0]       compare_output_latch
);
  // ==========================================================
  // pin synchronisers
  logic [2:0] portMeta;
  logic [2:0] portSync;
  logic [2:0] dirMeta;
  logic [2:0] dirSync;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      portMeta <= 3'h0;
      portSync <= 3'h0;
      dirMeta  <= 3'h0;
      dirSync  <= 3'h0;
    end else if (clkEn) begin
      portMeta <= portValuePin;
      portSync <= portMeta;
      dirMeta  <= pinDirPin;
      dirSync  <= dirMeta;
    end
  end

  // ==========================================================
  // registers
  logic [15:0] ctrl;
  logic [15:0] cmpVal [CH];
  logic [15:0] capture_value;
  logic        overflow_flag;
  logic [2:0]  channel_match_flag;
  logic        capture_flag;
  logic        blockNext;
  logic [2:0]  forceReq;
  logic [15:0] counter_value;
  logic        wrapEvt;

  wire logic [3:0] waveform_mode_select = ctrl[CTRL_MODE_LSB +: 4];
  wire logic [1:0] actField [CH];
  assign actField[0] = ctrl[CTRL_ACTA_LSB +: 2];
  assign actField[1] = ctrl[CTRL_ACTB_LSB +: 2];
  assign actField[2] = ctrl[CTRL_ACTC_LSB +: 2];

  wire logic wrCtrl  = regWr && regAddr == REG_CTRL;
  wire logic wrCount = regWr && regAddr == REG_COUNT;
  wire logic wrCapt  = regWr && regAddr == REG_CAPT;
  wire logic wrFlags = regWr && regAddr == REG_FLAGS;
  wire logic wrForce = regWr && regAddr == REG_FORCE;
  wire logic isPwm = !(waveform_mode_select == MODE_NORM ||
                       waveform_mode_select == MODE_CTCA ||
                       waveform_mode_select == MODE_CTCI);
  wire logic modeCapTop = waveform_mode_select == MODE_CTCI;
  wire logic [15:0] topValue = modeCapTop ? capture_value : cmpVal[0];
  wire logic tickNow = clkEn && timerTick;

  // ==========================================================
  // comparators with write blocking
  logic [2:0] chMatch;
  always_comb begin
    for (int i = 0; i < CH; i++) begin
      chMatch[i] = (counter_value == cmpVal[i]) && !blockNext;
    end
  end
  wire logic capTopMatch = modeCapTop && (counter_value == capture_value) &&
                           !blockNext;
  // a count write also hides the top match from the counter
  wire logic [15:0] topGated = blockNext ? ~counter_value : topValue;

  // force applies only outside pwm modes
  wire logic [2:0] next_force = (wrForce && !isPwm) ? regWData[2:0] :
                                3'h0;

  // ==========================================================
  // register writes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl          <= RST_WORD;
      capture_value <= RST_WORD;
      forceReq      <= 3'h0;
      for (int i = 0; i < CH; i++) begin
        cmpVal[i] <= RST_WORD;
      end
    end else if (clkEn) begin
      forceReq <= next_force;
      if (wrCtrl) begin
        ctrl <= regWData;
      end
      if (wrCapt) begin
        capture_value <= regWData;
      end
      for (int i = 0; i < CH; i++) begin
        if (regWr && regAddr == REG_CMPA + 4'(i)) begin
          cmpVal[i] <= regWData;
        end
      end
    end
  end

  // counter write blocks matches until the next tick has passed
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      blockNext <= 1'b0;
    end else if (clkEn) begin
      if (wrCount) begin
        blockNext <= 1'b1;
      end else if (timerTick) begin
        blockNext <= 1'b0;
      end
    end
  end

  // ==========================================================
  // flags: hardware set wins over software or acknowledge clear
  wire logic [2:0] setMatch = tickNow ? chMatch : 3'h0;
  wire logic setOvf = clkEn && wrapEvt;
  wire logic setCap = (tickNow && capTopMatch) || (clkEn && captureEvt);
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      overflow_flag      <= 1'b0;
      channel_match_flag <= 3'h0;
      capture_flag       <= 1'b0;
    end else if (clkEn) begin
      if (setOvf) begin
        overflow_flag <= 1'b1;
      end else if (ovfIntAck || (wrFlags && regWData[FLG_OVF])) begin
        overflow_flag <= 1'b0;
      end
      for (int i = 0; i < CH; i++) begin
        if (setMatch[i]) begin
          channel_match_flag[i] <= 1'b1;
        end else if (wrFlags && regWData[FLG_CMPA + i]) begin
          channel_match_flag[i] <= 1'b0;
        end
      end
      if (setCap) begin
        capture_flag <= 1'b1;
      end else if (capIntAck || (wrFlags && regWData[FLG_CAPT])) begin
        capture_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read port
  logic [15:0] rdMux;
  always_comb begin
    case (regAddr)
      REG_CTRL:  rdMux = ctrl;
      REG_COUNT: rdMux = counter_value;
      REG_CMPA:  rdMux = cmpVal[0];
      REG_CMPB:  rdMux = cmpVal[1];
      REG_CMPC:  rdMux = cmpVal[2];
      REG_CAPT:  rdMux = capture_value;
      REG_FLAGS: rdMux = {11'h000, capture_flag, channel_match_flag,
                          overflow_flag};
      REG_PORT:  rdMux = {10'h000, dirSync, compare_output_latch};
      default:   rdMux = RST_WORD;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regRData <= RST_WORD;
    end else if (clkEn) begin
      regRData <= regRd ? rdMux : RST_WORD;
    end
  end

  // ==========================================================
  // counter and output channels
  tcm_counter u_counter (
    .clk_sys              (clk_sys),
    .rst_n                (rst_n),
    .clkEn                (clkEn),
    .tick                 (timerTick),
    .waveform_mode_select (waveform_mode_select),
    .cntWrite             (wrCount),
    .cntWData             (regWData),
    .topValue             (topGated),
    .counter_value        (counter_value),
    .wrapEvt              (wrapEvt)
  );

  for (genvar g = 0; g < CH; g++) begin : gCh
    tcm_out_latch u_latch (
      .clk_sys                     (clk_sys),
      .rst_n                       (rst_n),
      .clkEn                       (clkEn),
      .tick                        (timerTick && !isPwm),
      .match                       (chMatch[g]),
      .force_compare_strobe        (forceReq[g]),
      .compare_output_action_field (actField[g]),
      .portValue                   (portSync[g]),
      .output_pin_direction_bit    (dirSync[g]),
      .compare_output_latch        (compare_output_latch[g]),
      .pinOut                      (pinOut[g]),
      .pinOe                       (pinOe[g])
    );
  end

  // ==========================================================
  // checks
  a_ovf_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && tickNow && !isPwm && !wrCount && counter_value == CNT_MAX &&
    !(waveform_mode_select != MODE_NORM && counter_value == topValue)
    |=> ##1 overflow_flag) else $error("overflow flag missing");
  a_match_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tickNow && chMatch[0] |=> channel_match_flag[0])
    else $error("match flag not set");
  a_write_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && wrCount |=> !chMatch[0] && !chMatch[1] && !chMatch[2])
    else $error("match not blocked");
  a_force_noflag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && forceReq[0] && !setMatch[0] && !channel_match_flag[0] &&
    !(wrFlags) |=> !channel_match_flag[0])
    else $error("force set flag");
  a_ovf_ack: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && ovfIntAck && !setOvf |=> !overflow_flag)
    else $error("overflow not cleared");
  a_pin_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !pinOe[0] |-> !pinOut[0]) else $error("pin driven as input");

  // ==========================================================
  // further checks on pins, flags, force, counting, registers and freeze
  a_cap_top: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tickNow && capTopMatch |=> capture_flag)
    else $error("capture top flag missing");
  a_match_b: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tickNow && chMatch[1] |=> channel_match_flag[1])
    else $error("match flag b not set");
  a_match_c: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tickNow && chMatch[2] |=> channel_match_flag[2])
    else $error("match flag c not set");
  a_ack_cap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && capIntAck && !setCap |=> !capture_flag)
    else $error("capture flag not cleared");
  a_flags_rst: assert property (@(posedge clk_sys) !rst_n |=>
    !overflow_flag && !capture_flag && channel_match_flag == 3'h0)
    else $error("flags not cleared by reset");
  a_force_pwm: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && isPwm |=> forceReq == 3'h0)
    else $error("force taken in pwm mode");
  a_force_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && forceReq[0] && actField[0] == ACT_SET |=> compare_output_latch[0])
    else $error("forced set missing");
  a_force_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && forceReq[0] && actField[0] == ACT_CLEAR |=> !compare_output_latch[0])
    else $error("forced clear missing");
  a_block_top: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tickNow && blockNext && !wrCount && !isPwm && counter_value != CNT_MAX
    |=> counter_value == $past(counter_value) + 16'h0001)
    else $error("blocked tick did not count");
  a_latch_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && actField[0] != ACT_NONE && dirSync[0] |=>
    pinOut[0] == $past(compare_output_latch[0]))
    else $error("latch not on pin");
  a_port_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && actField[0] == ACT_NONE && dirSync[0] |=>
    pinOut[0] == $past(portSync[0]))
    else $error("port value not on pin");
  a_oe_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn |=> pinOe == $past(dirSync))
    else $error("enable not following direction");
  a_rd_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && !regRd |=> regRData == RST_WORD)
    else $error("read data outside read cycle");
  a_freeze_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !clkEn |=> $stable(counter_value) && $stable(ctrl) &&
    $stable(compare_output_latch))
    else $error("state moved while frozen");
  a_cmp_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && wrFlags && regWData[FLG_CMPA] && !setMatch[0] |=> !channel_match_flag[0])
    else $error("match flag not cleared");
  a_ovf_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && wrFlags && regWData[FLG_OVF] && !setOvf |=> !overflow_flag)
    else $error("overflow flag not cleared by write");
  a_ctrl_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && wrCtrl |=> ctrl == $past(regWData))
    else $error("control write lost");
  a_cap_evt: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clkEn && captureEvt |=> capture_flag)
    else $error("capture event flag missing");

  // ==========================================================
  // scenario covers
  c_force: cover property (@(posedge clk_sys)
    clkEn && forceReq[0]);
  c_cap_top: cover property (@(posedge clk_sys)
    tickNow && capTopMatch);
  c_toggle: cover property (@(posedge clk_sys)
    compare_output_latch[0] ##[1:20] !compare_output_latch[0]);
  c_ctc_top: cover property (@(posedge clk_sys)
    tickNow && waveform_mode_select == MODE_CTCA && chMatch[0]);
  c_wrap: cover property (@(posedge clk_sys) setOvf);
endmodule

// >>> tb_tcm_timer16.sv
// Purpose: self-checking bench for the timer compare output stage
// Assumes: one timer tick per timerTick pulse, clkEn high unless frozen
// Notes:   assertions live in the design files
`timescale 1ns/10ps
module tb_tcm_timer16
  import tcm_pkg::*;
;
  // ==========================================================
  // signals
  typedef struct packed {
    logic [3:0]  mode;
    logic [1:0]  ch;
    logic [1:0]  act;
    logic        pre;
    logic [15:0] cmp;
    logic        expLatch;
    logic [15:0] expCount;
  } tcm_row_s;

  localparam int LAT = 0;
  localparam int PIN = 1;
  localparam int OE  = 2;

  logic        clk_sys      = 1'h0;
  logic        rst_n        = 1'h0;
  logic        clkEn        = 1'h1;
  logic        timerTick    = 1'h0;
  logic [3:0]  regAddr      = 4'h0;
  logic [15:0] regWData     = 16'h0000;
  logic        regWr        = 1'h0;
  logic        regRd        = 1'h0;
  logic        ovfIntAck    = 1'h0;
  logic        capIntAck    = 1'h0;
  logic        captureEvt   = 1'h0;
  logic [2:0]  portValuePin = 3'h0;
  logic [2:0]  pinDirPin    = 3'h0;
  logic [15:0] regRData;
  logic [2:0]  pinOut;
  logic [2:0]  pinOe;
  logic [2:0]  latchOut;
  logic [2:0]  expL         = 3'h0;
  tcm_row_s    r;
  int          pos;
  int          badCount     = 0;
  int          comparisons  = 0;

  tcm_row_s rows [8] = '{
    '{4'h0, 2'h0, 2'h1, 1'h0, 16'h0003, 1'h1, 16'h0004},
    '{4'h0, 2'h0, 2'h1, 1'h1, 16'h0003, 1'h0, 16'h0004},
    '{4'h0, 2'h1, 2'h2, 1'h1, 16'h0002, 1'h0, 16'h0003},
    '{4'h0, 2'h2, 2'h3, 1'h0, 16'h0001, 1'h1, 16'h0002},
    '{4'h0, 2'h1, 2'h0, 1'h1, 16'h0002, 1'h1, 16'h0003},
    '{4'h4, 2'h0, 2'h1, 1'h0, 16'h0003, 1'h1, 16'h0000},
    '{4'h4, 2'h2, 2'h2, 1'h1, 16'h0002, 1'h0, 16'h0003},
    '{4'h4, 2'h1, 2'h3, 1'h0, 16'h0001, 1'h1, 16'h0002}
  };

  always #5 clk_sys = ~clk_sys;

  tcm_timer16 uut (
    .clk_sys              (clk_sys),
    .rst_n                (rst_n),
    .clkEn                (clkEn),
    .timerTick            (timerTick),
    .regAddr              (regAddr),
    .regWData             (regWData),
    .regWr                (regWr),
    .regRd                (regRd),
    .ovfIntAck            (ovfIntAck),
    .capIntAck            (capIntAck),
    .captureEvt           (captureEvt),
    .portValuePin         (portValuePin),
    .pinDirPin            (pinDirPin),
    .regRData             (regRData),
    .pinOut               (pinOut),
    .pinOe                (pinOe),
    .compare_output_latch (latchOut)
  );

  // ==========================================================
  // tasks
  task automatic endSim();
    if (badCount == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWData <= d;
    regWr    <= 1'h1;
    @(posedge clk_sys);
    regWr    <= 1'h0;
  endtask

  task automatic chkReg(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] got;
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'h1;
    @(posedge clk_sys);
    regRd   <= 1'h0;
    #1;
    got = regRData;
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: reg %h read %h not %h", $time, a, got,
               exp);
    end
  endtask

  task automatic chkBits(input int sel, input logic [2:0] exp);
    logic [2:0] got;
    repeat (4) @(posedge clk_sys);
    #1;
    got = (sel == LAT) ? latchOut : (sel == PIN) ? pinOut : pinOe;
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected at %0t: bits %0d got %b not %b", $time, sel, got,
               exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      timerTick <= 1'h1;
      @(posedge clk_sys);
      timerTick <= 1'h0;
    end
    #1;
  endtask

  task automatic pulse(input int s);
    @(posedge clk_sys);
    ovfIntAck  <= (s == 0);
    capIntAck  <= (s == 1);
    captureEvt <= (s == 2);
    @(posedge clk_sys);
    {ovfIntAck, capIntAck, captureEvt} <= 3'h0;
  endtask

  // ==========================================================
  // sequence
  initial begin
    #200000;
    badCount++;
    endSim();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'h1;
    chkBits(LAT, 3'h0);
    wr(4'hf, 16'hffff);
    chkReg(4'hf, 16'h0000);
    foreach (rows[i]) begin
      r = rows[i];
      pos = CTRL_ACTA_LSB + 2 * int'(r.ch);
      wr(REG_CTRL, 16'((r.pre ? 3 : 2) << pos));
      wr(REG_FORCE, 16'(1 << r.ch));
      wr(REG_CTRL, 16'(r.mode) | (16'(r.act) << pos));
      wr(4'(REG_CMPA + 4'(r.ch)), r.cmp);
      wr(REG_COUNT, 16'h0000);
      wr(REG_FLAGS, 16'h001f);
      ticks(int'(r.cmp) + 1);
      expL[r.ch] = r.expLatch;
      chkBits(LAT, expL);
      chkReg(REG_COUNT, r.expCount);
      chkReg(REG_FLAGS, 16'h0001 << (r.ch + 1));
      wr(4'(REG_CMPA + 4'(r.ch)), 16'h00ff);
    end
    // pin override and direction
    wr(REG_CTRL, 16'h0010);
    @(posedge clk_sys);
    portValuePin <= 3'h5;
    chkBits(PIN, 3'h0);
    chkBits(OE, 3'h0);
    @(posedge clk_sys);
    pinDirPin <= 3'h7;
    chkBits(PIN, {2'h2, expL[0]});
    chkBits(OE, 3'h7);
    chkReg(REG_PORT, 16'h0038 | 16'(expL));
    wr(REG_CTRL, 16'h0000);
    chkBits(PIN, 3'h5);
    // blocking by count write, then forced compare
    wr(REG_CTRL, 16'h0010);
    wr(REG_CMPA, 16'h0005);
    wr(REG_COUNT, 16'h0005);
    wr(REG_FLAGS, 16'h001f);
    ticks(1);
    chkBits(LAT, expL);
    chkReg(REG_FLAGS, 16'h0000);
    wr(REG_FORCE, 16'h0001);
    expL[0] = ~expL[0];
    chkBits(LAT, expL);
    chkReg(REG_COUNT, 16'h0006);
    chkReg(REG_FLAGS, 16'h0000);
    wr(REG_CTRL, 16'h0015);
    wr(REG_FORCE, 16'h0001);
    chkBits(LAT, expL);
    // normal mode overflow
    wr(REG_CTRL, 16'h0000);
    wr(REG_COUNT, 16'hffff);
    wr(REG_FLAGS, 16'h001f);
    ticks(1);
    chkReg(REG_COUNT, 16'h0000);
    chkReg(REG_FLAGS, 16'h0001);
    pulse(0);
    chkReg(REG_FLAGS, 16'h0000);
    // clear-on-match toggle waveform, period then maximum rate
    wr(REG_CTRL, 16'h0014);
    wr(REG_CMPA, 16'h0002);
    wr(REG_COUNT, 16'h0000);
    for (int k = 1; k <= 13; k++) begin
      ticks(1);
      if (k > 9 || k % 3 == 0) begin
        expL[0] = ~expL[0];
      end
      chkBits(LAT, expL);
      if (k == 9) begin
        wr(REG_CMPA, 16'h0000);
      end
    end
    // top written below the count
    wr(REG_CMPA, 16'h000a);
    wr(REG_COUNT, 16'h0005);
    wr(REG_CMPA, 16'h0002);
    ticks(3);
    chkReg(REG_COUNT, 16'h0008);
    wr(REG_COUNT, 16'hfffe);
    wr(REG_FLAGS, 16'h001f);
    ticks(2);
    chkReg(REG_FLAGS, 16'h0001);
    ticks(3);
    expL[0] = ~expL[0];
    chkReg(REG_COUNT, 16'h0000);
    chkReg(REG_FLAGS, 16'h0003);
    // capture register as top
    wr(REG_CTRL, 16'h003c);
    wr(REG_CAPT, 16'h0003);
    wr(REG_COUNT, 16'h0000);
    wr(REG_FLAGS, 16'h001f);
    ticks(4);
    expL[0] = 1'h1;
    chkReg(REG_COUNT, 16'h0000);
    chkReg(REG_FLAGS, 16'h0012);
    chkBits(LAT, expL);
    wr(REG_FLAGS, 16'h001f);
    pulse(2);
    chkReg(REG_FLAGS, 16'h0010);
    pulse(1);
    chkReg(REG_FLAGS, 16'h0000);
    // count written equal to top misses the clear once
    wr(REG_COUNT, 16'h0003);
    ticks(1);
    chkReg(REG_COUNT, 16'h0004);
    // freeze, then reset in mid-run with clkEn low
    @(posedge clk_sys);
    clkEn <= 1'h0;
    ticks(3);
    @(posedge clk_sys);
    clkEn <= 1'h1;
    chkReg(REG_COUNT, 16'h0004);
    @(posedge clk_sys);
    rst_n <= 1'h0;
    clkEn <= 1'h0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'h1;
    clkEn <= 1'h1;
    chkBits(LAT, 3'h0);
    endSim();
  end
endmodule
